// >>> design/sfe_pkg.sv
`default_nettype none
package sfe_pkg;
   // Frame geometry
   localparam int FRAME_LEN = 160;
   localparam int SEG_LEN   = 40;
   localparam int NUM_SEG   = 4;
   // Input scaling and filter shifts
   localparam int DOWN_SHR  = 3;
   localparam int UP_SHL    = 2;
   localparam int FILT_SHR  = 15;
   // Filter and rounding constants (32735, 16384)
   localparam logic signed [15:0] HPF_COEF   = 16'sh7fdf;
   localparam logic signed [31:0] ROUND_HALF = 32'sh0000_4000;
   // Saturation limits
   localparam logic signed [15:0] MAX16 = 16'sh7fff;
   localparam logic signed [15:0] MIN16 = 16'sh8000;
   localparam logic signed [31:0] MAX32 = 32'sh7fff_ffff;
   localparam logic signed [31:0] MIN32 = 32'sh8000_0000;
   // Home-state values
   localparam logic signed [15:0] PREV_RST = 16'sh0000;
   localparam logic signed [31:0] RECF_RST = 32'sh0000_0000;

   typedef enum logic [3:0] {
      OP_ADD, OP_SUB, OP_MULT, OP_MULT_R, OP_ABS, OP_DIV,
      OP_WMULT, OP_WADD, OP_WSUB, OP_SHL, OP_SHR, OP_WSHL,
      OP_WSHR, OP_DEPOSIT, OP_EXTRACT
   } sfe_op_t;

   // Sample word with its frame marker
   typedef struct packed {
      logic               last;
      logic signed [15:0] data;
   } sfe_smp_t;

   // Arithmetic request
   typedef struct packed {
      sfe_op_t            code;
      logic signed [31:0] a;
      logic signed [31:0] b;
   } sfe_req_t;

   function automatic logic signed [15:0] sfe_add
      (input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [16:0] s;
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15]) return s[16] ? MIN16 : MAX16;
      return s[15:0];
   endfunction : sfe_add

   function automatic logic signed [15:0] sfe_sub
      (input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [16:0] s;
      s = {a[15], a} - {b[15], b};
      if (s[16] != s[15]) return s[16] ? MIN16 : MAX16;
      return s[15:0];
   endfunction : sfe_sub

   function automatic logic signed [15:0] sfe_mult
      (input logic signed [15:0] a, input logic signed [15:0] b,
       input logic rnd);
      logic signed [31:0] p;
      p = a * b;
      if (rnd) p = p + ROUND_HALF;
      if (a == MIN16 && b == MIN16) return MAX16;
      return p[30:15];
   endfunction : sfe_mult

   function automatic logic signed [15:0] sfe_abs
      (input logic signed [15:0] a);
      if (a == MIN16) return MAX16;
      return a[15] ? -a : a;
   endfunction : sfe_abs

   // Restoring division, 15 quotient bits; equal operands give 32767
   function automatic logic signed [15:0] sfe_div
      (input logic signed [15:0] n, input logic signed [15:0] d);
      logic [31:0] r;
      logic [15:0] q;
      r = {16'h0000, n};
      q = 16'h0000;
      for (int k = 0; k < 15; k++) begin
         q = {q[14:0], 1'b0};
         r = {r[30:0], 1'b0};
         if (r >= {16'h0000, d}) begin
            r = r - {16'h0000, d};
            q = q | 16'h0001;
         end
      end
      return q;
   endfunction : sfe_div

   function automatic logic signed [31:0] sfe_wmult
      (input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [31:0] p;
      p = a * b;
      return {p[30:0], 1'b0};
   endfunction : sfe_wmult

   function automatic logic signed [31:0] sfe_wadd
      (input logic signed [31:0] a, input logic signed [31:0] b);
      logic signed [32:0] s;
      s = {a[31], a} + {b[31], b};
      if (s[32] != s[31]) return s[32] ? MIN32 : MAX32;
      return s[31:0];
   endfunction : sfe_wadd

   function automatic logic signed [31:0] sfe_wsub
      (input logic signed [31:0] a, input logic signed [31:0] b);
      logic signed [32:0] s;
      s = {a[31], a} - {b[31], b};
      if (s[32] != s[31]) return s[32] ? MIN32 : MAX32;
      return s[31:0];
   endfunction : sfe_wsub

   function automatic logic signed [31:0] sfe_ext
      (input logic signed [15:0] a);
      return {{16{a[15]}}, a};
   endfunction : sfe_ext

   // Shift of a 32-bit value; left=1 means left for a positive count
   function automatic logic signed [31:0] sfe_shift
      (input logic signed [31:0] a, input logic signed [15:0] n,
       input logic left);
      logic [16:0] m;
      logic        go_left;
      m       = n[15] ? 17'(-{n[15], n}) : {1'b0, n};
      go_left = left ^ n[15];
      return go_left ? (a <<< m) : (a >>> m);
   endfunction : sfe_shift
endpackage : sfe_pkg
`default_nettype wire

// >>> design/sfe_frontend.sv
// What this block does
// - 16-bit add and subtract clamp to +32767 or -32768, never wrap.
// - Scaled multiply gives product shifted right 15; -32768 squared gives 32767.
// - Rounded multiply adds 16384 before shifting 15; corner saturates to 32767.
// - Absolute value of 16-bit input; -32768 gives 32767.
// - Fractional divide of positive num by larger-or-equal denominator; equal gives 32767.
// - Wide product is 32-bit multiply shifted left by one.
// - 32-bit add and subtract clamp to 2147483647 or -2147483648.
// - 16-bit into 32-bit sign-extends through the upper half.
// - 32-bit into 16-bit keeps low half only, no saturation.
// - Constants in 32-bit operations are sign-extended first.
// - Right shift arithmetic, left zero-fill; negative count reverses direction.
// - Only 13 valid sample bits are used; low 3 bits ignored.
// - Input handled in 160-sample frames of four 40-sample segments.
// - Frame-level results delivered once per frame, covering all 160 samples.
// - Each of four segments is marked for the per-segment parameter stages.
// - Sample shifted right by 3 then left by 2 before filtering.
// - Non-recursive part: saturated difference to previous sample, then store it.
// - Recursive part: 31x16 multiply by 32735 forms new 32-bit state.
// - Output is saturated state plus 16384, shifted right by 15.
// - Previous sample and recursive state persist across frames, zero at reset.
// - Homing returns filter and frame state to zero before the next frame.
`default_nettype none
module sfe_frontend
   import sfe_pkg::*;
#(
   parameter int FRAME_SAMPLES = FRAME_LEN
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   // Homing request
   input  wire logic        i_home,
   // Raw sample input
   input  wire logic        i_in_valid,
   input  wire logic        i_in_first,
   input  wire logic [15:0] i_in_data,
   output logic             o_in_ready,
   // Filtered sample output
   output logic             o_out_valid,
   output logic             o_out_last,
   output logic [15:0]      o_out_data,
   input  wire logic        i_out_ready,
   // Frame progress
   output logic             o_seg_done,
   output logic [1:0]       o_seg_idx,
   output logic             o_frame_done,
   // Arithmetic unit
   input  wire logic        i_op_valid,
   input  wire logic [3:0]  i_op_code,
   input  wire logic [31:0] i_op_a,
   input  wire logic [31:0] i_op_b,
   output logic             o_op_done,
   output logic [31:0]      o_op_res
);

   typedef struct packed {
      logic signed [15:0] prev_input_state;
      logic signed [31:0] recursive_filter_state;
      logic [5:0]         pos;
      logic [1:0]         seg;
      logic [1:0]         cnt;
      sfe_smp_t           buf0;
      sfe_smp_t           buf1;
      logic [1:0]         seg_idx;
      logic               seg_done;
      logic               frame_done;
      logic               op_done;
      logic signed [31:0] op_res;
   } sfe_state_t;

   sfe_state_t st_ff;
   sfe_state_t nxt_st;

   logic               accept;
   logic               pop;
   logic signed [15:0] so;
   logic signed [15:0] s1;
   logic signed [31:0] ls2;
   logic signed [15:0] msp;
   logic signed [31:0] lsp;
   logic signed [15:0] lsp_tmp;
   logic signed [31:0] new_state;
   logic signed [15:0] sof;
   logic [5:0]         pos_cur;
   logic [1:0]         seg_cur;
   logic               seg_end;
   logic               frame_end;
   sfe_req_t           req;
   logic signed [15:0] a16;
   logic signed [15:0] b16;
   logic signed [31:0] op_val;

   // Handshakes; homing blocks intake so no sample straddles it
   assign o_in_ready  = (st_ff.cnt != 2'd2) && !i_home;
   assign accept      = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_valid = (st_ff.cnt != 2'd0);
   assign o_out_data  = st_ff.buf0.data;
   assign o_out_last  = st_ff.buf0.last;
   assign o_seg_done  = st_ff.seg_done;
   assign o_seg_idx   = st_ff.seg_idx;
   assign o_frame_done = st_ff.frame_done;
   assign o_op_done   = st_ff.op_done;
   assign o_op_res    = st_ff.op_res;

   // Offset compensation datapath, one sample per cycle
   always_comb begin
      // Low 3 bits never reach the arithmetic
      so = 16'(sfe_ext(16'($signed(i_in_data) >>> DOWN_SHR))
               <<< UP_SHL);
      s1 = sfe_sub(so, st_ff.prev_input_state);
      ls2 = sfe_ext(s1) <<< FILT_SHR;
      msp = 16'(st_ff.recursive_filter_state >>> FILT_SHR);
      lsp = sfe_wsub(st_ff.recursive_filter_state,
                     sfe_ext(msp) <<< FILT_SHR);
      lsp_tmp = sfe_mult(lsp[15:0], HPF_COEF, 1'b1);
      ls2 = sfe_wadd(ls2, sfe_ext(lsp_tmp));
      new_state = sfe_wadd(sfe_wmult(msp, HPF_COEF) >>> 1, ls2);
      sof = 16'(sfe_wadd(new_state, ROUND_HALF) >>> FILT_SHR);
   end

   // Position in frame; the marker resynchronises the count
   always_comb begin
      pos_cur   = i_in_first ? 6'h00 : st_ff.pos;
      seg_cur   = i_in_first ? 2'h0 : st_ff.seg;
      seg_end   = (pos_cur == 6'(SEG_LEN - 1));
      frame_end = seg_end &&
                  (seg_cur == 2'(FRAME_SAMPLES / SEG_LEN - 1));
   end

   // Arithmetic unit operand views
   always_comb begin
      req    = '{code: sfe_op_t'(i_op_code), a: i_op_a, b: i_op_b};
      a16    = req.a[15:0];
      b16    = req.b[15:0];
      op_val = 32'h0000_0000;
      case (req.code)
         OP_ADD:     op_val = sfe_ext(sfe_add(a16, b16));
         OP_SUB:     op_val = sfe_ext(sfe_sub(a16, b16));
         OP_MULT:    op_val = sfe_ext(sfe_mult(a16, b16, 1'b0));
         OP_MULT_R:  op_val = sfe_ext(sfe_mult(a16, b16, 1'b1));
         OP_ABS:     op_val = sfe_ext(sfe_abs(a16));
         OP_DIV:     op_val = sfe_ext(sfe_div(a16, b16));
         OP_WMULT:   op_val = sfe_wmult(a16, b16);
         OP_WADD:    op_val = sfe_wadd(req.a, req.b);
         OP_WSUB:    op_val = sfe_wsub(req.a, req.b);
         OP_SHL:     op_val = sfe_ext(16'(sfe_shift(sfe_ext(a16),
                                      b16, 1'b1)));
         OP_SHR:     op_val = sfe_ext(16'(sfe_shift(sfe_ext(a16),
                                      b16, 1'b0)));
         OP_WSHL:    op_val = sfe_shift(req.a, b16, 1'b1);
         OP_WSHR:    op_val = sfe_shift(req.a, b16, 1'b0);
         OP_DEPOSIT: op_val = sfe_ext(a16);
         OP_EXTRACT: op_val = {16'h0000, a16};
         default:    op_val = 32'h0000_0000;
      endcase
   end

   // Next-state: buffer, filter memory, counters, strobes
   always_comb begin
      nxt_st            = st_ff;
      nxt_st.seg_done   = 1'b0;
      nxt_st.frame_done = 1'b0;
      nxt_st.op_done    = i_op_valid;
      if (i_op_valid) begin
         nxt_st.op_res = op_val;
      end
      // Two-entry skid: a stalled reader loses nothing
      if (pop) begin
         nxt_st.buf0 = st_ff.buf1;
         nxt_st.cnt  = st_ff.cnt - 2'd1;
      end
      if (accept) begin
         if (nxt_st.cnt == 2'd0) begin
            nxt_st.buf0 = '{last: frame_end, data: sof};
         end else begin
            nxt_st.buf1 = '{last: frame_end, data: sof};
         end
         nxt_st.cnt = nxt_st.cnt + 2'd1;
         // Filter memory carries over frame boundaries
         nxt_st.prev_input_state       = so;
         nxt_st.recursive_filter_state = new_state;
         nxt_st.pos        = seg_end ? 6'h00 : pos_cur + 6'h01;
         nxt_st.seg        = seg_end ? (frame_end ? 2'h0 :
                             seg_cur + 2'h1) : seg_cur;
         nxt_st.seg_done   = seg_end;
         nxt_st.seg_idx    = seg_cur;
         nxt_st.frame_done = frame_end;
      end
      // Homing zeroes the filter and realigns the frame
      if (i_home) begin
         nxt_st.prev_input_state       = PREV_RST;
         nxt_st.recursive_filter_state = RECF_RST;
         nxt_st.pos = 6'h00;
         nxt_st.seg = 2'h0;
      end
   end

   // State register; reset is the home state
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   chk_add_clamp: assert property (
      i_op_valid && i_op_code == OP_ADD && i_op_a[15:0] == 16'h7fff &&
      i_op_b[15:0] == 16'h0001 |=> o_op_done && o_op_res == 32'h0000_7fff)
      else $error("16-bit add did not clamp high");
   chk_sub_clamp: assert property (
      i_op_valid && i_op_code == OP_SUB && i_op_a[15:0] == 16'h8000 &&
      i_op_b[15:0] == 16'h0001 |=> o_op_res == 32'hffff_8000)
      else $error("16-bit subtract did not clamp low");
   chk_mult_corner: assert property (
      i_op_valid && i_op_code == OP_MULT && i_op_a[15:0] == 16'h8000 &&
      i_op_b[15:0] == 16'h8000 |=> o_op_res == 32'h0000_7fff)
      else $error("scaled multiply corner not saturated");
   chk_multr_round: assert property (
      i_op_valid && i_op_code == OP_MULT_R && i_op_a[15:0] == 16'h0001 &&
      i_op_b[15:0] == 16'h4000 |=> o_op_res == 32'h0000_0001)
      else $error("rounded multiply did not round");
   chk_abs_corner: assert property (
      i_op_valid && i_op_code == OP_ABS && i_op_a[15:0] == 16'h8000
      |=> o_op_res == 32'h0000_7fff)
      else $error("abs of most negative not saturated");
   chk_div_equal: assert property (
      i_op_valid && i_op_code == OP_DIV && i_op_a[15:0] == i_op_b[15:0] &&
      i_op_a[15] == 1'b0 && i_op_a[15:0] != 16'h0000
      |=> o_op_res == 32'h0000_7fff)
      else $error("divide of equal operands not 32767");
   chk_wadd_clamp: assert property (
      i_op_valid && i_op_code == OP_WADD && i_op_a == 32'h7fff_ffff &&
      i_op_b == 32'h0000_0001 |=> o_op_res == 32'h7fff_ffff)
      else $error("32-bit add did not clamp");
   chk_shr_negative: assert property (
      i_op_valid && i_op_code == OP_SHR && i_op_a[15:0] == 16'h0001 &&
      i_op_b[15:0] == 16'hfffe |=> o_op_res == 32'h0000_0004)
      else $error("negative right shift did not shift left");
   chk_home_zero: assert property (
      i_home |=> st_ff.prev_input_state == PREV_RST &&
      st_ff.recursive_filter_state == RECF_RST && st_ff.pos == 6'h00)
      else $error("homing left filter state nonzero");
   chk_prev_update: assert property (
      accept && !i_home |=> st_ff.prev_input_state ==
      16'($signed({$past(i_in_data[15:3]), 2'b00})))
      else $error("previous sample not the rescaled input");
   chk_frame_done: assert property (
      o_frame_done |-> $past(accept) && o_seg_idx == 2'h3 && o_seg_done)
      else $error("frame done without closing sample");
   chk_buf_hold: assert property (
      o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
      else $error("stalled output word changed or lost");

   // Width conversions: extract zero-fills, deposit sign-extends
   chk_extract_low: assert property (
      i_op_valid && i_op_code == OP_EXTRACT
      |=> o_op_res == {16'h0000, $past(i_op_a[15:0])})
      else $error("extract did not keep the low half");
   chk_deposit_sext: assert property (
      i_op_valid && i_op_code == OP_DEPOSIT
      |=> o_op_res == {{16{$past(i_op_a[15])}}, $past(i_op_a[15:0])})
      else $error("deposit did not sign-extend");
   // Wide arithmetic corners, plus 16-bit abs of -1 and negative left shift
   chk_wsub_clamp: assert property (
      i_op_valid && i_op_code == OP_WSUB && i_op_a == 32'h8000_0000 &&
      i_op_b == 32'h0000_0001 |=> o_op_res == 32'h8000_0000)
      else $error("32-bit subtract did not clamp");
   chk_wmult_shift: assert property (
      i_op_valid && i_op_code == OP_WMULT && i_op_a[15:0] == 16'h4000 &&
      i_op_b[15:0] == 16'h4000 |=> o_op_res == 32'h2000_0000)
      else $error("wide product not doubled");
   chk_abs_plain: assert property (
      i_op_valid && i_op_code == OP_ABS && i_op_a[15:0] == 16'hffff
      |=> o_op_res == 32'h0000_0001)
      else $error("abs of minus one not one");
   chk_shl_negative: assert property (
      i_op_valid && i_op_code == OP_SHL && i_op_a[15:0] == 16'hfff0 &&
      i_op_b[15:0] == 16'hffff |=> o_op_res == 32'hffff_fff8)
      else $error("negative left shift did not shift right");
   // Stream side: a full buffer must refuse, strobes follow intake
   chk_ready_full: assert property (
      st_ff.cnt == 2'd2 |-> !o_in_ready)
      else $error("full buffer still ready");
   chk_seg_source: assert property (
      o_seg_done |-> $past(accept))
      else $error("segment strobe without intake");

   cov_frame: cover property (o_frame_done);
   cov_full: cover property (st_ff.cnt == 2'd2 ##1 pop);
   cov_home: cover property (i_home ##1 accept);
   cov_seg: cover property (o_seg_done && o_seg_idx == 2'h1);

endmodule : sfe_frontend
`default_nettype wire

// >>> verif/sfe_stream_partner.sv
`default_nettype none
module sfe_stream_partner
   import sfe_pkg::*;
(
   // Clock, reset and pacing
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_slow,
   // Sample source side
   output logic             o_in_valid,
   output logic             o_in_first,
   output logic [15:0]      o_in_data,
   input  wire logic        i_in_ready,
   // Sample sink side
   input  wire logic        i_out_valid,
   input  wire logic        i_out_last,
   input  wire logic [15:0] i_out_data,
   output logic             o_out_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   // Outgoing words use the flag as frame-start marker
   sfe_smp_t   tx_q[$];
   sfe_smp_t   rx_q[$];
   logic       taken;
   logic [1:0] pace;

   initial begin
      o_in_valid  = 1'b0;
      o_in_first  = 1'b0;
      o_in_data   = 16'h0000;
      o_out_ready = 1'b0;
      taken       = 1'b0;
      pace        = 2'h0;
   end

   // Handshakes are judged at the rising edge only
   always @(posedge i_ref_clk) begin
      taken = o_in_valid && i_in_ready && !i_sys_rst;
      if (i_out_valid && o_out_ready && !i_sys_rst) begin
         rx_q.push_back({i_out_last, i_out_data});
      end
      pace = pace + 2'h1;
   end

   // Request held until taken; idle data toggles so stale words show
   always @(negedge i_ref_clk) begin
      if (taken) begin
         tx_q.delete(0);
      end
      if (o_in_valid && !taken) begin
         o_in_valid = 1'b1;
      end else if (tx_q.size() != 0 && (!i_slow || pace[0])) begin
         o_in_valid = 1'b1;
         o_in_first = tx_q[0].last;
         o_in_data  = tx_q[0].data;
      end else begin
         o_in_valid = 1'b0;
         o_in_first = 1'b0;
         o_in_data  = ~o_in_data;
      end
      o_out_ready = !i_slow || (pace == 2'h0);
   end
endmodule : sfe_stream_partner
`default_nettype wire

// >>> verif/sfe_frontend_tb.sv
`default_nettype none
module sfe_frontend_tb
   import sfe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk, sys_rst, home, slow;
   logic        in_valid, in_first, in_ready, out_valid, out_last;
   logic        out_ready, seg_done, frame_done, op_valid, op_done;
   logic [15:0] in_data, out_data;
   logic [1:0]  seg_idx, pidx;
   logic [3:0]  op_code;
   logic [31:0] op_a, op_b, op_res;
   logic        pend, pend_f;
   int          fails, samples_checked, cycles, pos, refusals;
   longint      ref_prev, ref_recf;

   initial ref_clk = 1'b0;
   always #2.5 ref_clk = ~ref_clk;

   sfe_frontend #(.FRAME_SAMPLES(FRAME_LEN)) DUT (
      .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_home(home),
      .i_in_valid(in_valid), .i_in_first(in_first), .i_in_data(in_data),
      .o_in_ready(in_ready), .o_out_valid(out_valid),
      .o_out_last(out_last), .o_out_data(out_data),
      .i_out_ready(out_ready), .o_seg_done(seg_done),
      .o_seg_idx(seg_idx), .o_frame_done(frame_done),
      .i_op_valid(op_valid), .i_op_code(op_code), .i_op_a(op_a),
      .i_op_b(op_b), .o_op_done(op_done), .o_op_res(op_res));

   sfe_stream_partner u_partner (
      .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_slow(slow),
      .o_in_valid(in_valid), .o_in_first(in_first), .o_in_data(in_data),
      .i_in_ready(in_ready), .i_out_valid(out_valid),
      .i_out_last(out_last), .i_out_data(out_data),
      .o_out_ready(out_ready));

   task automatic bad(string msg);
      $display("BAD %0t %s", $time, msg);
      fails++;
   endtask : bad

   task automatic check(logic [31:0] got, logic [31:0] exp, string what);
      samples_checked++;
      if (got !== exp) bad($sformatf("%s got %h want %h", what, got, exp));
   endtask : check

   task automatic conclude();
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // Hang guard, well above the roughly one thousand cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad("timeout");
         conclude();
      end
   end

   // Independent position count predicts every segment and frame strobe
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         pos = 0;
         pend = 1'b0;
         pend_f = 1'b0;
      end else begin
         samples_checked++;
         if (seg_done !== pend || frame_done !== pend_f ||
             (pend && seg_idx !== pidx)) bad("segment strobe");
         pend = 1'b0;
         pend_f = 1'b0;
         if (home) pos = 0;
         if (in_valid && !in_ready) refusals++;
         if (in_valid && in_ready) begin
            if (in_first) pos = 0;
            pend = (pos % SEG_LEN) == SEG_LEN - 1;
            pidx = 2'(pos / SEG_LEN);
            pend_f = pos == FRAME_LEN - 1;
            pos = (pos + 1) % FRAME_LEN;
         end
      end
   end

   function automatic longint sat(longint v, int w);
      longint hi;
      hi = (longint'(1) <<< (w - 1)) - 1;
      if (v > hi) return hi;
      if (v < -hi - 1) return -hi - 1;
      return v;
   endfunction : sat

   // Reference offset filter; msp and lsp are 16-bit words as in hardware
   function automatic logic [15:0] filt(logic [15:0] sop);
      longint x, s1, ls2, msp, lsp;
      x = (longint'($signed(sop)) >>> 3) * 4;
      s1 = sat(x - ref_prev, 16);
      ref_prev = x;
      msp = longint'($signed(16'(ref_recf >>> 15)));
      lsp = sat(ref_recf - msp * 32768, 32);
      lsp = longint'($signed(16'(lsp)));
      ls2 = sat(s1 * 32768 + ((lsp * 32735 + 16384) >>> 15), 32);
      ref_recf = sat(msp * 32735 + ls2, 32);
      return 16'(sat(ref_recf + 16384, 32) >>> 15);
   endfunction : filt

   task automatic do_op(sfe_op_t code, logic [31:0] a, b, exp);
      op_valid = 1'b1;
      op_code = code;
      op_a = a;
      op_b = b;
      @(negedge ref_clk);
      check({31'h0, op_done}, 32'h1, "op done");
      check(op_res, exp, "op result");
   endtask : do_op

   task automatic t_reset_state();
      check({31'h0, out_valid}, 32'h0, "valid after reset");
      check({31'h0, in_ready}, 32'h1, "ready after reset");
      check(op_res, 32'h0, "result after reset");
   endtask : t_reset_state

   task automatic t_arith();
      do_op(OP_ADD, 32'h7fff, 32'h1, 32'h7fff);
      do_op(OP_ADD, 32'h8000, 32'hffff, 32'hffff8000);
      do_op(OP_SUB, 32'h8000, 32'h1, 32'hffff8000);
      do_op(OP_SUB, 32'h7fff, 32'hffff, 32'h7fff);
      do_op(OP_MULT, 32'h8000, 32'h8000, 32'h7fff);
      do_op(OP_MULT, 32'hc000, 32'h4000, 32'hffffe000);
      do_op(OP_MULT, 32'h1, 32'h4000, 32'h0);
      do_op(OP_MULT_R, 32'h1, 32'h4000, 32'h1);
      do_op(OP_MULT_R, 32'h8000, 32'h8000, 32'h7fff);
      do_op(OP_ABS, 32'h8000, 32'h0, 32'h7fff);
      do_op(OP_ABS, 32'hffff, 32'h0, 32'h1);
      do_op(OP_DIV, 32'h1000, 32'h1000, 32'h7fff);
      do_op(OP_DIV, 32'h1, 32'h3, 32'h2aaa);
      do_op(OP_WMULT, 32'h4000, 32'h4000, 32'h20000000);
      do_op(OP_WMULT, 32'hffff, 32'h3, 32'hfffffffa);
      do_op(OP_WADD, 32'h7fffffff, 32'h1, 32'h7fffffff);
      do_op(OP_WADD, 32'h80000000, 32'hffffffff, 32'h80000000);
      do_op(OP_WSUB, 32'h80000000, 32'h1, 32'h80000000);
      do_op(OP_WSUB, 32'h7fffffff, 32'hffffffff, 32'h7fffffff);
      do_op(OP_WADD, 32'h5, 32'hfffffffe, 32'h3);
      do_op(OP_DEPOSIT, 32'h12348001, 32'h0, 32'hffff8001);
      do_op(OP_EXTRACT, 32'h12348001, 32'h0, 32'h8001);
      do_op(OP_SHL, 32'h3, 32'h2, 32'hc);
      do_op(OP_SHL, 32'hfff0, 32'hffff, 32'hfffffff8);
      do_op(OP_SHR, 32'h8000, 32'h4, 32'hfffff800);
      do_op(OP_SHR, 32'h3, 32'hfffe, 32'hc);
      do_op(OP_WSHL, 32'h1, 32'h1f, 32'h80000000);
      do_op(OP_WSHR, 32'h80000000, 32'h1f, 32'hffffffff);
      do_op(OP_WSHR, 32'h40000000, 32'hffff, 32'h80000000);
      do_op(sfe_op_t'(4'hf), 32'h7, 32'h7, 32'h0);
      op_valid = 1'b0;
      @(negedge ref_clk);
      check({31'h0, op_done}, 32'h0, "done is one pulse");
   endtask : t_arith

   // One stream of n words; low three bits carry junk on purpose
   task automatic t_stream(int n, bit first, bit slow_mode);
      logic [15:0] sops[$];
      sfe_smp_t    w;
      int          t;
      slow = slow_mode;
      for (int k = 0; k < n; k++) begin
         sops.push_back(16'(k * 2731 + n * 97));
         u_partner.tx_q.push_back({first && k == 0, sops[k]});
      end
      t = 0;
      while (u_partner.rx_q.size() < n && t < 5000) begin
         @(negedge ref_clk);
         t++;
      end
      check(32'(u_partner.rx_q.size()), 32'(n), "word count");
      for (int k = 0; k < n && u_partner.rx_q.size() != 0; k++) begin
         w = u_partner.rx_q.pop_front();
         check({16'h0, w.data}, {16'h0, filt(sops[k])}, "sample");
         check({31'h0, w.last}, 32'(k == FRAME_LEN - 1), "last");
      end
      check({31'h0, out_valid}, 32'h0, "drained");
   endtask : t_stream

   task automatic t_home();
      t_stream(20, 1'b1, 1'b0);
      home = 1'b1;
      #1;
      check({31'h0, in_ready}, 32'h0, "ready during homing");
      @(negedge ref_clk);
      home = 1'b0;
      ref_prev = 0;
      ref_recf = 0;
      t_stream(FRAME_LEN, 1'b0, 1'b0);
   endtask : t_home

   initial begin
      sys_rst = 1'b1;
      home = 1'b0;
      slow = 1'b0;
      op_valid = 1'b0;
      op_code = 4'h0;
      op_a = 32'h0;
      op_b = 32'h0;
      ref_prev = 0;
      ref_recf = 0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 1'b0;
      t_reset_state();
      t_arith();
      t_stream(FRAME_LEN, 1'b1, 1'b0);
      refusals = 0;
      t_stream(FRAME_LEN, 1'b1, 1'b1);
      check(32'(refusals > 0), 32'h1, "buffer refused");
      t_home();
      conclude();
   end
endmodule : sfe_frontend_tb
`default_nettype wire
